// >>> ecp_regs.svh
// constants for the eight channel pwm core
`ifndef ECP_REGS_SVH
`define ECP_REGS_SVH
`define ECP_NUM_CH 8
`define ECP_CNT_W 8
`define ECP_PER_RST 8'hFF
`define ECP_DTY_RST 8'hFF
`define ECP_CLKSEL_RST 8'h00
`define ECP_CLKAB_RST 8'hCC
`define ECP_SCALE_FULL 9'h100
`endif

// >>> ecp_pkg.sv
// types for the eight channel pwm core
package ecp_pkg;
  typedef logic [7:0] ecp_byte_t;
  // one channel's register state
  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] per_buf;
    logic [7:0] dty_buf;
    logic [7:0] per_act;
    logic [7:0] dty_act;
    logic down;
    logic q;
    logic run;
    logic zero_rst;
  } ecp_chan_s;
  // one channel's static controls
  typedef struct packed {
    logic en;
    logic pol;
    logic cae;
    logic scaled;
    logic base_b;
  } ecp_chcfg_s;
  // scaler state
  typedef struct packed {
    logic [7:0] cnt;
    logic div2;
  } ecp_scl_s;
endpackage

// >>> ecp_channel.sv
// one pwm channel timer
`timescale 1ns/100ps
`include "ecp_regs.svh"
module ecp_channel (
  input wire logic clk, // bus clock
  input wire logic rst, // sync reset
  input wire ecp_pkg::ecp_chcfg_s cfg, // channel controls
  input wire logic tick, // selected channel clock enable
  input wire logic cnt_wr, // counter write strobe
  input wire logic per_wr, // period write strobe
  input wire logic dty_wr, // duty write strobe
  input wire logic [7:0] wdata, // write data
  output logic [7:0] cnt_rd, // counter value
  output logic [7:0] per_rd, // last written period
  output logic [7:0] dty_rd, // last written duty
  output logic pwm_out // waveform
);
  ecp_pkg::ecp_chan_s st;
  ecp_pkg::ecp_chan_s next_st;

  // counter, buffers and output flip-flop
  always_comb begin
    next_st = st;
    // edge synchroniser: the channel runs only from a clock tick after enable
    if (!cfg.en) begin
      next_st.run = 1'b0;
    end else if (tick) begin
      next_st.run = 1'b1;
    end
    if (per_wr) begin
      next_st.per_buf = wdata;
      if (!cfg.en) begin
        next_st.per_act = wdata;
        next_st.zero_rst = (wdata == 8'h00);
      end
    end
    if (dty_wr) begin
      next_st.dty_buf = wdata;
      if (!cfg.en) begin
        next_st.dty_act = wdata;
      end
    end
    // disabling the channel drops buffered values into the active latches
    if (!cfg.en && !per_wr && !dty_wr) begin
      next_st.per_act = st.per_buf;
      next_st.dty_act = st.dty_buf;
    end
    if (!cfg.en && tick && st.zero_rst) begin
      next_st.cnt = 8'h00;
      next_st.zero_rst = per_wr & (wdata == 8'h00); // a fresh zero write wins over the clear
    end
    if (cnt_wr) begin
      next_st.cnt = 8'h00;
      next_st.down = 1'b0;
      next_st.q = 1'b0;
      next_st.per_act = st.per_buf;
      next_st.dty_act = st.dty_buf;
    end else if (cfg.en && st.run && tick) begin
      // counter holds while disabled since this branch needs cfg.en
      if (!cfg.cae) begin
        if (st.cnt + 8'h01 == st.per_act || st.cnt == st.per_act) begin
          next_st.cnt = 8'h00;
          next_st.q = 1'b0;
          next_st.per_act = st.per_buf;
          next_st.dty_act = st.dty_buf;
        end else begin
          next_st.cnt = st.cnt + 8'h01;
          if (st.cnt + 8'h01 == st.dty_act) begin
            next_st.q = ~st.q;
          end
        end
      end else begin
        if (!st.down) begin
          if (st.cnt + 8'h01 >= st.per_act) begin
            next_st.down = 1'b1;
          end
          next_st.cnt = (st.cnt >= st.per_act) ? st.cnt - 8'h01 : st.cnt + 8'h01;
        end else if (st.cnt == 8'h01 || st.cnt == 8'h00) begin
          next_st.cnt = 8'h00;
          next_st.down = 1'b0;
          next_st.per_act = st.per_buf;
          next_st.dty_act = st.dty_buf;
        end else begin
          next_st.cnt = st.cnt - 8'h01;
        end
        if (next_st.cnt == st.dty_act && next_st.cnt != st.cnt) begin
          next_st.q = ~st.q;
        end
      end
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '{cnt: 8'h00, per_buf: `ECP_PER_RST, dty_buf: `ECP_DTY_RST,
              per_act: `ECP_PER_RST, dty_act: `ECP_DTY_RST,
              down: 1'b0, q: 1'b0, run: 1'b0, zero_rst: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign cnt_rd = st.cnt;
  assign per_rd = st.per_buf;
  assign dty_rd = st.dty_buf;
  // polarity picks q or not q
  assign pwm_out = cfg.en & (cfg.pol ? ~st.q : st.q);

  // assertions
  AST_CNT_WR_CLEARS: assert property (@(posedge clk) disable iff (rst)
    cnt_wr |=> (cnt_rd == 8'h00))
    else $error("counter not cleared by write");
  AST_HOLD_DISABLED: assert property (@(posedge clk) disable iff (rst)
    (!cfg.en && !cnt_wr && !st.zero_rst) |=> $stable(cnt_rd))
    else $error("counter moved while disabled");
  AST_DIS_WRITE_ACT: assert property (@(posedge clk) disable iff (rst)
    (per_wr && !cfg.en) |=> (st.per_act == $past(wdata)))
    else $error("period latch not written while disabled");
  AST_LEFT_BOUND: assert property (@(posedge clk) disable iff (rst)
    (cfg.en && !cfg.cae && st.per_act != 8'h00 && $stable(cfg.cae) && !cnt_wr
     && $past(cnt_rd) < st.per_act && !per_wr) |-> (cnt_rd <= st.per_act))
    else $error("left aligned count ran past period");
  COV_CNT_WR: cover property (@(posedge clk) cnt_wr);
  COV_CENTER_TURN: cover property (@(posedge clk) cfg.cae && $rose(st.down));
  COV_TOGGLE: cover property (@(posedge clk) cfg.en && $changed(pwm_out));
endmodule // ecp_channel

// >>> ecp_core.sv
// eight channel pwm core: clock generation and channel array
// How it works
// - base clocks A and B divide bus clock by 1..128 per 3-bit field
// - freeze gate bit plus freeze mode stops the prescaler input
// - all channels disabled stops the prescaler input
// - scaled clocks use 8-bit down counter, reload at one, then divide by two
// - scale zero means 256, giving divide by 512
// - writing a scale value reloads its down counter immediately
// - each channel picks base A, scaled A, base B or scaled B
// - reset selects base A for channels 0,1,4,5 and base B otherwise
// - each channel has 8-bit counter, period and duty
// - enable acts at once; waveform starts at next selected clock tick
// - disabled counter holds and resumes from held value
// - polarity set starts high, goes low at duty; clear is inverse
// - duty match toggles output flip-flop
// - enabled writes buffer until period end, counter write or disable
// - disabled writes update buffer and active latch together
// - counter write clears count, direction up, loads buffers, resets output
// - counter reads never disturb counting
// - disabled zero period write clears counter on next channel tick
// - counter clears at end of each effective period
// - left aligned counts up 0 to period minus 1
// - center aligned turns down at period, up at zero, loads buffers
`timescale 1ns/100ps
`include "ecp_regs.svh"
module ecp_core (
  input wire logic clk, // bus clock, 125 MHz
  input wire logic rst, // sync reset, active high
  input wire logic freeze_mode, // freeze mode signal, async
  input wire logic freeze_gate_bit, // gate prescaler in freeze
  input wire logic [2:0] base_a_divide_sel, // clock A divisor select
  input wire logic [2:0] base_b_divide_sel, // clock B divisor select
  input wire logic [7:0] scale_a_value, // scale A data
  input wire logic scale_a_wr, // scale A write strobe
  input wire logic [7:0] scale_b_value, // scale B data
  input wire logic scale_b_wr, // scale B write strobe
  input wire logic [7:0] channel_enable_bit, // per channel enable
  input wire logic [7:0] channel_polarity_bit, // per channel polarity
  input wire logic [7:0] center_align_bit, // per channel alignment
  input wire logic [7:0] clk_sel_wdata, // scaled select write data
  input wire logic clk_sel_wr, // scaled select write strobe
  input wire logic [7:0] clk_ab_wdata, // base ab select write data
  input wire logic clk_ab_wr, // base ab select write strobe
  input wire logic [7:0] wdata, // channel register write data
  input wire logic [7:0] cnt_wr, // counter write strobes
  input wire logic [7:0] per_wr, // period write strobes
  input wire logic [7:0] dty_wr, // duty write strobes
  output logic [63:0] channel_counter, // counters, ch0 in low byte
  output logic [63:0] channel_period, // period read back
  output logic [63:0] channel_duty, // duty read back
  output logic [7:0] chan_scaled_select, // clock select state
  output logic [7:0] chan_base_ab_select, // clock ab select state
  output logic [7:0] pwm_out // waveform pins
);
  // ************************************
  // state
  // ************************************
  typedef struct packed {
    logic frz_s1;
    logic frz_s2;
    logic [6:0] pre;
    logic [7:0] sel;
    logic [7:0] ab;
    ecp_pkg::ecp_scl_s sa;
    ecp_pkg::ecp_scl_s sb;
  } ecp_core_s;

  ecp_core_s st;
  ecp_core_s next_st;
  logic pre_en;
  logic [7:0] pre_next;
  logic tick_a;
  logic tick_b;
  logic tick_sa;
  logic tick_sb;
  logic pulse_a;
  logic pulse_b;

  // prescaler runs only when not frozen and some channel is on
  assign pre_en = !(freeze_gate_bit && st.frz_s2)
                  && (channel_enable_bit != 8'h00);
  assign pre_next = {1'b0, st.pre} + 8'h01;

  // a base tick fires when the low bits below the divisor all roll over
  function automatic logic div_tick(input logic [6:0] c, input logic [2:0] s);
    logic [6:0] m;
    m = 7'(({7'h00, 1'b1} << s) - 8'h01);
    div_tick = ((c & m) == m);
  endfunction

  assign tick_a = pre_en && div_tick(st.pre, base_a_divide_sel);
  assign tick_b = pre_en && div_tick(st.pre, base_b_divide_sel);
  // scaler pulse on reaching one; a zero load counts 256 ticks
  assign pulse_a = tick_a && (st.sa.cnt == 8'h01);
  assign pulse_b = tick_b && (st.sb.cnt == 8'h01);
  // divide by two: scaled tick on every second pulse
  assign tick_sa = pulse_a && st.sa.div2;
  assign tick_sb = pulse_b && st.sb.div2;

  // ************************************
  // clock generation
  // ************************************
  always_comb begin
    next_st = st;
    next_st.frz_s1 = freeze_mode;
    next_st.frz_s2 = st.frz_s1;
    if (pre_en) begin
      next_st.pre = pre_next[6:0];
    end
    if (scale_a_wr) begin
      next_st.sa.cnt = scale_a_value;
    end else if (pulse_a) begin
      next_st.sa.cnt = scale_a_value;
      next_st.sa.div2 = ~st.sa.div2;
    end else if (tick_a) begin
      next_st.sa.cnt = st.sa.cnt - 8'h01;
    end
    if (scale_b_wr) begin
      next_st.sb.cnt = scale_b_value;
    end else if (pulse_b) begin
      next_st.sb.cnt = scale_b_value;
      next_st.sb.div2 = ~st.sb.div2;
    end else if (tick_b) begin
      next_st.sb.cnt = st.sb.cnt - 8'h01;
    end
    if (clk_sel_wr) begin
      next_st.sel = clk_sel_wdata;
    end
    if (clk_ab_wr) begin
      next_st.ab = clk_ab_wdata;
    end
  end

  // registered state
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '{frz_s1: 1'b0, frz_s2: 1'b0, pre: 7'h00,
              sel: `ECP_CLKSEL_RST, ab: `ECP_CLKAB_RST,
              sa: '{cnt: 8'h00, div2: 1'b0}, sb: '{cnt: 8'h00, div2: 1'b0}};
    end else begin
      st <= next_st;
    end
  end

  assign chan_scaled_select = st.sel;
  assign chan_base_ab_select = st.ab;

  // ************************************
  // channels
  // ************************************
  genvar g;
  generate
    for (g = 0; g < `ECP_NUM_CH; g++) begin : g_ch
      ecp_pkg::ecp_chcfg_s cfg;
      logic tick;
      assign cfg = '{en: channel_enable_bit[g], pol: channel_polarity_bit[g],
                     cae: center_align_bit[g], scaled: st.sel[g], base_b: st.ab[g]};
      // four way clock choice
      always_comb begin
        unique case ({cfg.base_b, cfg.scaled})
          2'b00: tick = tick_a;
          2'b01: tick = tick_sa;
          2'b10: tick = tick_b;
          2'b11: tick = tick_sb;
        endcase
      end
      ecp_channel ecp_channel_i (
        .clk(clk),
        .rst(rst),
        .cfg(cfg),
        .tick(tick),
        .cnt_wr(cnt_wr[g]),
        .per_wr(per_wr[g]),
        .dty_wr(dty_wr[g]),
        .wdata(wdata),
        .cnt_rd(channel_counter[8*g +: 8]),
        .per_rd(channel_period[8*g +: 8]),
        .dty_rd(channel_duty[8*g +: 8]),
        .pwm_out(pwm_out[g])
      );
    end
  endgenerate

  // ************************************
  // checks
  // ************************************
  AST_FREEZE_HALTS: assert property (@(posedge clk) disable iff (rst)
    (freeze_gate_bit && st.frz_s2) |-> !tick_a && !tick_b)
    else $error("prescaler ran in freeze");
  AST_ALL_OFF_HALTS: assert property (@(posedge clk) disable iff (rst)
    (channel_enable_bit == 8'h00) |=> $stable(st.pre))
    else $error("prescaler ran with all channels off");
  AST_DIV1: assert property (@(posedge clk) disable iff (rst)
    (pre_en && base_a_divide_sel == 3'h0) |-> tick_a)
    else $error("divide by one missed a tick");
  AST_SCALE_RELOAD: assert property (@(posedge clk) disable iff (rst)
    scale_a_wr |=> (st.sa.cnt == $past(scale_a_value)))
    else $error("scale write did not reload");
  AST_PULSE_RELOAD: assert property (@(posedge clk) disable iff (rst)
    (pulse_a && !scale_a_wr) |=> (st.sa.cnt == $past(scale_a_value)) && $changed(st.sa.div2))
    else $error("scaler pulse without reload");
  AST_ZERO_COUNTS: assert property (@(posedge clk) disable iff (rst)
    (tick_a && !scale_a_wr && st.sa.cnt == 8'h00) |=> (st.sa.cnt == 8'hFF))
    else $error("zero scale did not wrap to full count");
  COV_SCALED_A: cover property (@(posedge clk) tick_sa);
  COV_FREEZE: cover property (@(posedge clk) freeze_gate_bit && st.frz_s2);
endmodule // ecp_core

// >>> ecp_core_tb.sv
// self-checking bench for the eight channel pwm core
`timescale 1ns/100ps
module ecp_core_tb;
  // ****
  // stimulus and observed signals
  // ****
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic freeze_mode = 1'b0;
  logic freeze_gate_bit = 1'b0;
  logic [2:0] base_a_divide_sel = 3'h0;
  logic [2:0] base_b_divide_sel = 3'h0;
  logic [7:0] scale_a_value = 8'h00;
  logic [7:0] scale_b_value = 8'h00;
  logic scale_a_wr = 1'b0;
  logic scale_b_wr = 1'b0;
  logic [7:0] channel_enable_bit = 8'h00;
  logic [7:0] channel_polarity_bit = 8'h00;
  logic [7:0] center_align_bit = 8'h00;
  logic [7:0] clk_sel_wdata = 8'h00;
  logic clk_sel_wr = 1'b0;
  logic [7:0] clk_ab_wdata = 8'hCC;
  logic clk_ab_wr = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] cnt_wr = 8'h00;
  logic [7:0] per_wr = 8'h00;
  logic [7:0] dty_wr = 8'h00;
  logic [63:0] channel_counter, channel_period, channel_duty;
  logic [7:0] chan_scaled_select, chan_base_ab_select, pwm_out;
  int failures = 0;
  int n_checks = 0;
  int cycles = 0;

  // every input is driven by the bench, none tied off
  ecp_core ecp_core_i (
    .clk(clk), .rst(rst), .freeze_mode(freeze_mode), .freeze_gate_bit(freeze_gate_bit),
    .base_a_divide_sel(base_a_divide_sel), .base_b_divide_sel(base_b_divide_sel),
    .scale_a_value(scale_a_value), .scale_a_wr(scale_a_wr), .scale_b_value(scale_b_value),
    .scale_b_wr(scale_b_wr), .channel_enable_bit(channel_enable_bit),
    .channel_polarity_bit(channel_polarity_bit), .center_align_bit(center_align_bit),
    .clk_sel_wdata(clk_sel_wdata), .clk_sel_wr(clk_sel_wr), .clk_ab_wdata(clk_ab_wdata),
    .clk_ab_wr(clk_ab_wr), .wdata(wdata), .cnt_wr(cnt_wr), .per_wr(per_wr), .dty_wr(dty_wr),
    .channel_counter(channel_counter), .channel_period(channel_period),
    .channel_duty(channel_duty), .chan_scaled_select(chan_scaled_select),
    .chan_base_ab_select(chan_base_ab_select), .pwm_out(pwm_out)
  );

  // 125 MHz bus clock
  always #4 clk = ~clk;

  // hang guard, the full run needs well under a quarter of this
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      close_out();
    end
  end

  // ****
  // helpers
  // ****
  function automatic logic [7:0] cn(input int ch);
    return channel_counter[ch*8 +: 8];
  endfunction

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  task automatic close_out();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // one channel register write: k 0 counter, 1 period, 2 duty
  task automatic wr(input int k, input int ch, input logic [7:0] v);
    @(posedge clk);
    wdata <= v;
    if (k == 0) cnt_wr[ch] <= 1'b1;
    if (k == 1) per_wr[ch] <= 1'b1;
    if (k == 2) dty_wr[ch] <= 1'b1;
    @(posedge clk);
    cnt_wr <= 8'h00;
    per_wr <= 8'h00;
    dty_wr <= 8'h00;
  endtask

  // bounded wait, in the settled phase, for a channel 1 count
  task automatic wait_cnt(input logic [7:0] v);
    int i;
    for (i = 0; i < 64 && cn(1) !== v; i++) begin
      @(posedge clk);
      #1;
    end
    chk(i < 64, 1'b1);
  endtask

  // route a clock to ch0, restart its count, expect two ticks per two tick periods
  task automatic rate(input logic s, b, input logic [2:0] ad, bd,
                      input logic [7:0] sa, sb, input int per);
    logic [7:0] v;
    @(posedge clk);
    clk_sel_wdata <= {7'h00, s};
    clk_ab_wdata <= {7'h66, b};
    clk_sel_wr <= 1'b1;
    clk_ab_wr <= 1'b1;
    base_a_divide_sel <= ad;
    base_b_divide_sel <= bd;
    scale_a_value <= sa;
    scale_b_value <= sb;
    scale_a_wr <= 1'b1;
    scale_b_wr <= 1'b1;
    wdata <= 8'h00;
    cnt_wr <= 8'h01;
    @(posedge clk);
    clk_sel_wr <= 1'b0;
    clk_ab_wr <= 1'b0;
    scale_a_wr <= 1'b0;
    scale_b_wr <= 1'b0;
    cnt_wr <= 8'h00;
    repeat (3) @(posedge clk);
    #1 v = cn(0);
    chk(chan_scaled_select, {7'h00, s});
    chk(chan_base_ab_select, {7'h66, b});
    repeat (2 * per) @(posedge clk);
    #1 chk(8'(cn(0) - v), 8'h02);
  endtask

  // ch1 at period 4 duty 1; 16 cycles span whole periods so phase drops out
  task automatic wave(input logic cae, pol, input int hi);
    int h, m;
    h = 0;
    m = 0;
    @(posedge clk);
    channel_enable_bit[1] <= 1'b0;
    channel_polarity_bit[1] <= pol;
    center_align_bit[1] <= cae;
    wr(1, 1, 8'h04);
    wr(2, 1, 8'h01);
    wr(0, 1, 8'h33);
    #1 chk(pwm_out[1], 1'b0);
    chk(cn(1), 8'h00);
    @(posedge clk);
    channel_enable_bit[1] <= 1'b1;
    repeat (4) @(posedge clk);
    repeat (16) begin
      @(posedge clk);
      #1 h += int'(pwm_out[1] === 1'b1);
      if (cn(1) > m) m = cn(1);
      if (cn(1) === 8'h00) chk(pwm_out[1], pol);
    end
    chk(h, hi);
    chk(m, cae ? 4 : 3);
  endtask

  // ****
  // test sequence
  // ****
  initial begin
    logic [7:0] v;
    int h, m;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 chk(channel_counter, 64'h0);
    chk(channel_period, {8{8'hFF}});
    chk(channel_duty, {8{8'hFF}});
    chk(chan_scaled_select, 8'h00);
    chk(chan_base_ab_select, 8'hCC);
    chk(pwm_out, 8'h00);
    done("reset");
    @(posedge clk);
    channel_enable_bit <= 8'h01;
    for (int n = 0; n < 8; n++) rate(0, 0, n[2:0], 3'h0, 8'h00, 8'h00, 1 << n);
    rate(1, 0, 3'h0, 3'h0, 8'h03, 8'h00, 6);
    rate(1, 0, 3'h0, 3'h0, 8'h01, 8'h00, 2);
    rate(1, 0, 3'h0, 3'h0, 8'h00, 8'h00, 512);
    rate(0, 1, 3'h0, 3'h2, 8'h00, 8'h00, 4);
    rate(1, 1, 3'h0, 3'h0, 8'h00, 8'h02, 4);
    done("clocks");
    wave(1, 0, 12);
    wave(1, 1, 4);
    wave(0, 1, 4);
    wave(0, 0, 12);
    done("waveform");
    // period written mid-cycle must wait for the wrap
    wait_cnt(8'h01);
    wr(1, 1, 8'h06);
    #1 chk(channel_period[15:8], 8'h06);
    wait_cnt(8'h03);
    @(posedge clk);
    #1 chk(cn(1), 8'h00);
    wr(2, 1, 8'h02);
    wr(0, 1, 8'h00);
    #1 chk(cn(1), 8'h00);
    chk(channel_duty[15:8], 8'h02);
    h = 0;
    m = 0;
    repeat (12) begin
      @(posedge clk);
      #1 h += int'(pwm_out[1] === 1'b1);
      if (cn(1) > m) m = cn(1);
    end
    chk(h, 8);
    chk(m, 5);
    done("buffering");
    // hold while disabled, then resume from the held count
    wait_cnt(8'h01);
    @(posedge clk);
    channel_enable_bit[1] <= 1'b0;
    repeat (3) @(posedge clk);
    #1 v = cn(1);
    repeat (10) @(posedge clk);
    #1 chk(cn(1), v);
    @(posedge clk);
    channel_enable_bit[1] <= 1'b1;
    for (int i = 0; i < 8 && cn(1) === v; i++) begin
      @(posedge clk);
      #1;
    end
    chk(cn(1), (v == 8'h05) ? 8'h00 : v + 8'h01);
    @(posedge clk);
    channel_enable_bit[1] <= 1'b0;
    wr(1, 1, 8'h00);
    repeat (3) @(posedge clk);
    #1 chk(cn(1), 8'h00);
    done("hold");
    // freeze stops ch0 on scaled clock b, release lets it run again
    @(posedge clk);
    freeze_gate_bit <= 1'b1;
    freeze_mode <= 1'b1;
    repeat (6) @(posedge clk);
    #1 v = cn(0);
    repeat (40) @(posedge clk);
    #1 chk(cn(0), v);
    @(posedge clk);
    freeze_mode <= 1'b0;
    repeat (20) @(posedge clk);
    #1 chk(cn(0) != v, 1'b1);
    done("freeze");
    close_out();
  end
endmodule // ecp_core_tb
